// >>> src/cad_consts.svh
// constant header for the arithmetic and dsp datapath
// assumes inclusion from the package only
`ifndef CAD_CONSTS_SVH
`define CAD_CONSTS_SVH

// register byte offsets on the avalon slave
`define CAD_OFS_CORE_CONTROL 5'h00
`define CAD_OFS_FLAG_REGISTER 5'h04
`define CAD_OFS_ACCUMULATOR_A_LO 5'h08
`define CAD_OFS_ACCUMULATOR_A_HI 5'h0C
`define CAD_OFS_ACCUMULATOR_B_LO 5'h10
`define CAD_OFS_ACCUMULATOR_B_HI 5'h14

// core_control fields
`define CAD_CC_INTEGER_SELECT 0
`define CAD_CC_ROUND_SELECT 1
`define CAD_CC_PSV 2
`define CAD_CC_PRIORITY_MSB 3
`define CAD_CC_CLAMP_WIDTH 4
`define CAD_CC_STORE_CLAMP 5
`define CAD_CC_ACC_B_CLAMP 6
`define CAD_CC_ACC_A_CLAMP 7
`define CAD_CC_UNSIGNED_MUL 12
`define CAD_CC_RESET 16'h0020
`define CAD_CC_WR_MASK 16'h10F7

// flag_register fields
`define CAD_FL_CARRY 0
`define CAD_FL_ZERO 1
`define CAD_FL_WRAP 2
`define CAD_FL_NEG 3
`define CAD_FL_IPL_LO 5
`define CAD_FL_HALF 8
`define CAD_FL_SB 12
`define CAD_FL_SA 13
`define CAD_FL_OB 14
`define CAD_FL_OA 15
`define CAD_FL_RESET 16'h0000

// saturation limits
`define CAD_SAT39_POS 40'h7FFFFFFFFF
`define CAD_SAT39_NEG 40'h8000000000
`define CAD_SAT31_POS 40'h007FFFFFFF
`define CAD_SAT31_NEG 40'hFF80000000
`define CAD_STORE_POS 16'h7FFF
`define CAD_STORE_NEG 16'h8000
`define CAD_ROUND_HALF 40'h0000008000

// divider iterations, one per divisor bit
`define CAD_DIV_STEPS 5'h10

`endif

// >>> src/cad_datapath.sv
// arithmetic datapath: integer alu, mcu multiply, iterative divider, dsp
// assumes the instruction decoder fetches operands and takes results
// How it works
// - 16-bit two's complement add, subtract, shift, logic
// - alu updates carry, zero, negative, wrap, half-carry
// - subtraction sets carry and half-carry as inverted borrows (set means no borrow)
// - byte or word operand size per instruction
// - operands and results in registers or memory
// - six mcu multiply modes, five on the shared multiplier
// - signed and unsigned 32/16 and 16/16 divide
// - quotient to quotient_reg, remainder to remainder_reg
// - any divisor register, even aligned dividend pair
// - one cycle per divisor bit, equal lengths
// - 17x17 multiplier, shifter, 40-bit adder, two accumulators
// - dsp and mcu work never overlap
// - accumulator add, subtract, negate need no operands
// - integer_select picks integer or fractional products
// - unsigned_multiply_sel picks unsigned dsp operands
// - round_select one biased, zero convergent
// - per-accumulator saturation enables
// - store_clamp_en saturates data-space writes
// - clamp_width_sel one super, zero normal saturation
// - priority msb tops three-bit priority field
// - accumulator ops and their write-back permission
// - super saturation loads 9.31 extremes
// - priority msb set disables user interrupts
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cad_datapath
  import cad_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // avalon-mm register slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // operation request from the decoder
  input wire logic op_valid,
  input wire cad_op_t op,
  output logic op_ready,
  // alu and multiply result
  output logic res_valid,
  output cad_res_t res,
  // divide result to fixed registers
  output logic div_valid,
  output logic [15:0] quotient_reg,
  output logic [15:0] remainder_reg,
  // accumulator write-back of the non-target accumulator
  output logic wb_valid,
  output logic [15:0] wb_data,
  // trap side
  input wire logic priority_msb_set,
  output logic [3:0] cpu_priority,
  output logic user_int_dis
);
  logic [15:0] core_control_q;
  logic [15:0] flag_q;
  logic [39:0] acc_a_q;
  logic [39:0] acc_b_q;
  logic ack_q;
  cad_div_state_t div_st_q;
  logic [4:0] div_cnt_q;
  logic [15:0] div_rem_q;
  logic [15:0] div_quo_q;
  logic [15:0] div_dvs_q;
  logic div_neg_q_q;
  logic div_neg_r_q;
  logic take;
  logic bus_wr;
  logic [15:0] opa;
  logic [15:0] alu_res;
  logic [4:0] alu_fl;
  logic [4:0] alu_fl_mask;
  logic [31:0] mul_res;
  logic [39:0] dsp_acc_d;
  logic dsp_upd;
  logic dsp_ov31;
  logic dsp_ov39;
  logic [16:0] dstep;

  function automatic logic [39:0] dsp_mul(input logic [15:0] x,
    input logic [15:0] y, input logic uns, input logic integ);
    logic signed [16:0] xs;
    logic signed [16:0] ys;
    logic signed [33:0] p;
    xs = uns ? $signed({1'b0, x}) : $signed({x[15], x});
    ys = uns ? $signed({1'b0, y}) : $signed({y[15], y});
    p = xs * ys;
    if (!integ) begin
      p = p <<< 1;
    end
    return {{7{p[32]}}, p[32:0]};
  endfunction : dsp_mul

  function automatic logic [15:0] mag16(input logic [15:0] v,
    input logic neg);
    return neg ? 16'(-v) : v;
  endfunction : mag16

  // one restoring step: remainder, incoming bit, divisor
  function automatic logic [16:0] div_step(input logic [15:0] r,
    input logic b, input logic [15:0] d);
    logic [16:0] t;
    t = {r, b} - {1'b0, d};
    return t[16] ? {1'b0, r[14:0], b} : {1'b1, t[15:0]};
  endfunction : div_step

  // rounded, optionally clamped high word of an accumulator
  function automatic logic [15:0] store_word(input logic [39:0] a,
    input logic biased, input logic clamp);
    logic [39:0] t;
    logic tie;
    tie = (a[15:0] == 16'h8000) && !a[16];
    t = a + ((biased || !tie) ? `CAD_ROUND_HALF : 40'h0);
    if (clamp && !(&t[39:31] || ~|t[39:31])) begin
      return t[39] ? `CAD_STORE_NEG : `CAD_STORE_POS;
    end
    return t[31:16];
  endfunction : store_word

  // avalon slave: one wait cycle, then the answer
  assign waitrequest = (read | write) & ~ack_q;
  assign bus_wr = write & ~ack_q & clk_en;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      readdata <= 32'h0;
    end else if (clk_en && read && !ack_q) begin
      unique case (address)
        `CAD_OFS_CORE_CONTROL: readdata <= {16'h0, core_control_q};
        `CAD_OFS_FLAG_REGISTER: readdata <= {16'h0, flag_q};
        `CAD_OFS_ACCUMULATOR_A_LO: readdata <= acc_a_q[31:0];
        `CAD_OFS_ACCUMULATOR_A_HI: readdata <= {24'h0, acc_a_q[39:32]};
        `CAD_OFS_ACCUMULATOR_B_LO: readdata <= acc_b_q[31:0];
        `CAD_OFS_ACCUMULATOR_B_HI: readdata <= {24'h0, acc_b_q[39:32]};
        default: readdata <= 32'h0;
      endcase
    end
  end

  // core_control: priority msb is clear-only by software, set by trap
  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_control_q <= `CAD_CC_RESET;
    end else if (clk_en) begin
      if (bus_wr && address == `CAD_OFS_CORE_CONTROL) begin
        core_control_q <= writedata[15:0] & `CAD_CC_WR_MASK;
        core_control_q[`CAD_CC_PRIORITY_MSB] <=
          core_control_q[`CAD_CC_PRIORITY_MSB] &
          writedata[`CAD_CC_PRIORITY_MSB];
      end
      if (priority_msb_set) begin
        core_control_q[`CAD_CC_PRIORITY_MSB] <= 1'b1;
      end
    end
  end

  assign cpu_priority = {core_control_q[`CAD_CC_PRIORITY_MSB],
    flag_q[`CAD_FL_IPL_LO+2:`CAD_FL_IPL_LO]};
  assign user_int_dis = core_control_q[`CAD_CC_PRIORITY_MSB];

  // one instruction at a time; divide holds off everything
  assign op_ready = (div_st_q == CAD_DIV_IDLE);
  assign take = op_valid & op_ready & clk_en;
  assign opa = op.src_mem ? op.mem_a : op.wreg_a;

  // integer alu, byte or word
  always_comb begin
    logic [16:0] s;
    logic [4:0] h;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] r;
    logic c;
    logic dc;
    s = 17'h0;
    h = 5'h0;
    c = 1'b0;
    dc = 1'b0;
    r = 16'h0;
    a = op.byte_mode ? {8'h0, opa[7:0]} : opa;
    b = op.byte_mode ? {8'h0, op.opb[7:0]} : op.opb;
    alu_fl_mask = 5'b01010;
    unique case (op.alu_op)
      CAD_ALU_ADD, CAD_ALU_SUB: begin
        if (op.alu_op == CAD_ALU_SUB) begin
          b = op.byte_mode ? {8'h0, ~b[7:0]} : ~b;
        end
        s = {1'b0, a} + {1'b0, b} + {16'h0, op.alu_op == CAD_ALU_SUB};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]}
          + {4'h0, op.alu_op == CAD_ALU_SUB};
        r = s[15:0];
        c = op.byte_mode ? s[8] : s[16];
        dc = h[4];
        alu_fl_mask = 5'b11111;
      end
      CAD_ALU_AND: r = a & b;
      CAD_ALU_OR: r = a | b;
      CAD_ALU_XOR: r = a ^ b;
      CAD_ALU_SHL: begin
        r = a << 1;
        c = op.byte_mode ? a[7] : a[15];
        alu_fl_mask = 5'b01011;
      end
      CAD_ALU_LSR: begin
        r = a >> 1;
        c = a[0];
        alu_fl_mask = 5'b01011;
      end
      CAD_ALU_ASR: begin
        r = {op.byte_mode ? 8'h0 : {a[15], a[15:9]},
          a[8], op.byte_mode ? a[7] : a[7], a[6:1]};
        if (op.byte_mode) begin
          r[7] = a[7];
        end
        c = a[0];
        alu_fl_mask = 5'b01011;
      end
    endcase
    if (op.byte_mode) begin
      r[15:8] = 8'h0;
    end
    alu_res = r;
    // order: half, neg, wrap, zero, carry
    alu_fl[0] = c;
    alu_fl[1] = op.byte_mode ? (r[7:0] == 8'h0) : (r == 16'h0);
    alu_fl[2] = op.byte_mode ? ((a[7] == b[7]) && (r[7] != a[7]))
      : ((a[15] == b[15]) && (r[15] != a[15]));
    alu_fl[3] = op.byte_mode ? r[7] : r[15];
    alu_fl[4] = dc;
  end

  // mcu multiplies share the dsp multiplier, except mixed-sign CAD_MUL_US
  always_comb begin
    logic [39:0] p;
    p = 40'h0;
    unique case (op.mul_mode)
      CAD_MUL_SS: p = dsp_mul(opa, op.opb, 1'b0, 1'b1);
      CAD_MUL_UU: p = dsp_mul(opa, op.opb, 1'b1, 1'b1);
      CAD_MUL_S_LIT: p = dsp_mul(opa, {11'h0, op.lit5}, 1'b0, 1'b1);
      CAD_MUL_U_LIT: p = dsp_mul(opa, {11'h0, op.lit5}, 1'b1, 1'b1);
      CAD_MUL_US: begin
        p = {8'h0, 32'($signed({1'b0, opa}) * $signed({op.opb[15],
          op.opb}))};
      end
      CAD_MUL_BYTE: begin
        p = dsp_mul({8'h0, opa[7:0]}, {8'h0, op.opb[7:0]}, 1'b1, 1'b1);
      end
      default: p = 40'h0;
    endcase
    mul_res = p[31:0];
  end

  // dsp accumulate path: 40-bit adder with saturation
  always_comb begin
    logic [39:0] tgt;
    logic [39:0] oth;
    logic [39:0] addend;
    logic [39:0] sum;
    logic [15:0] dif;
    logic sub;
    logic sat_en;
    logic sup;
    tgt = op.acc_b ? acc_b_q : acc_a_q;
    oth = op.acc_b ? acc_a_q : acc_b_q;
    dif = 16'(opa - op.opb);
    sub = 1'b0;
    dsp_upd = 1'b1;
    addend = 40'h0;
    unique case (op.dsp_op)
      CAD_DSP_ACCUM_ZERO: tgt = 40'h0;
      CAD_DSP_DIFF_SQUARE: begin
        addend = dsp_mul(dif, dif, core_control_q[`CAD_CC_UNSIGNED_MUL],
          core_control_q[`CAD_CC_INTEGER_SELECT]);
        tgt = 40'h0;
      end
      CAD_DSP_DIFF_SQUARE_ACCUM: begin
        addend = dsp_mul(dif, dif, core_control_q[`CAD_CC_UNSIGNED_MUL],
          core_control_q[`CAD_CC_INTEGER_SELECT]);
      end
      CAD_DSP_MULT_ACCUMULATE, CAD_DSP_MULT_SUBTRACT: begin
        addend = dsp_mul(opa, op.opb, core_control_q[`CAD_CC_UNSIGNED_MUL],
          core_control_q[`CAD_CC_INTEGER_SELECT]);
        sub = (op.dsp_op == CAD_DSP_MULT_SUBTRACT);
      end
      CAD_DSP_MULT_ACC_SQUARE: begin
        addend = dsp_mul(opa, opa, core_control_q[`CAD_CC_UNSIGNED_MUL],
          core_control_q[`CAD_CC_INTEGER_SELECT]);
      end
      CAD_DSP_PREFETCH_ONLY_WB: dsp_upd = 1'b0;
      CAD_DSP_MULTIPLY_LOAD, CAD_DSP_NEGATED_MULT_LOAD: begin
        addend = dsp_mul(opa, op.opb, core_control_q[`CAD_CC_UNSIGNED_MUL],
          core_control_q[`CAD_CC_INTEGER_SELECT]);
        sub = (op.dsp_op == CAD_DSP_NEGATED_MULT_LOAD);
        tgt = 40'h0;
      end
      CAD_DSP_MULTIPLY_LOAD_SQ: begin
        addend = dsp_mul(opa, opa, core_control_q[`CAD_CC_UNSIGNED_MUL],
          core_control_q[`CAD_CC_INTEGER_SELECT]);
        tgt = 40'h0;
      end
      CAD_DSP_ACC_ADD, CAD_DSP_ACC_SUB: begin
        addend = oth;
        sub = (op.dsp_op == CAD_DSP_ACC_SUB);
      end
      CAD_DSP_INVERT_SIGN_ACCUM: begin
        addend = tgt;
        tgt = 40'h0;
        sub = 1'b1;
      end
      default: dsp_upd = 1'b0;
    endcase
    if (sub) begin
      addend = ~addend;
    end
    sum = tgt + addend + {39'h0, sub};
    dsp_ov39 = (tgt[39] == addend[39]) && (sum[39] != tgt[39]);
    dsp_ov31 = !(&sum[39:31] || ~|sum[39:31]);
    sat_en = op.acc_b ? core_control_q[`CAD_CC_ACC_B_CLAMP]
      : core_control_q[`CAD_CC_ACC_A_CLAMP];
    sup = core_control_q[`CAD_CC_CLAMP_WIDTH];
    dsp_acc_d = sum;
    if (sat_en && dsp_ov39) begin
      if (sup) begin
        dsp_acc_d = tgt[39] ? `CAD_SAT39_NEG : `CAD_SAT39_POS;
      end else begin
        dsp_acc_d = tgt[39] ? `CAD_SAT31_NEG : `CAD_SAT31_POS;
      end
    end else if (sat_en && !sup && dsp_ov31) begin
      dsp_acc_d = sum[39] ? `CAD_SAT31_NEG : `CAD_SAT31_POS;
    end
  end

  // accumulators
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_a_q <= 40'h0;
      acc_b_q <= 40'h0;
    end else if (take && op.cls == CAD_CLS_DSP && dsp_upd) begin
      if (op.acc_b) begin
        acc_b_q <= dsp_acc_d;
      end else begin
        acc_a_q <= dsp_acc_d;
      end
    end
  end

  // write-back only for the four permitted operations
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_valid <= 1'b0;
      wb_data <= 16'h0;
    end else if (clk_en) begin
      wb_valid <= take && op.cls == CAD_CLS_DSP && op.wb_en &&
        (op.dsp_op == CAD_DSP_ACCUM_ZERO ||
         op.dsp_op == CAD_DSP_MULT_ACCUMULATE ||
         op.dsp_op == CAD_DSP_PREFETCH_ONLY_WB ||
         op.dsp_op == CAD_DSP_MULT_SUBTRACT);
      if (take && op.cls == CAD_CLS_DSP) begin
        wb_data <= store_word(op.acc_b ? acc_a_q : acc_b_q,
          core_control_q[`CAD_CC_ROUND_SELECT],
          core_control_q[`CAD_CC_STORE_CLAMP]);
      end
    end
  end

  // flag_register: hardware events win over a software write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_q <= `CAD_FL_RESET;
    end else if (clk_en) begin
      if (bus_wr && address == `CAD_OFS_FLAG_REGISTER) begin
        flag_q <= writedata[15:0];
        flag_q[`CAD_FL_SA] <= flag_q[`CAD_FL_SA] & writedata[`CAD_FL_SA];
        flag_q[`CAD_FL_SB] <= flag_q[`CAD_FL_SB] & writedata[`CAD_FL_SB];
      end
      if (take && op.cls == CAD_CLS_ALU) begin
        if (alu_fl_mask[0]) flag_q[`CAD_FL_CARRY] <= alu_fl[0];
        if (alu_fl_mask[1]) flag_q[`CAD_FL_ZERO] <= alu_fl[1];
        if (alu_fl_mask[2]) flag_q[`CAD_FL_WRAP] <= alu_fl[2];
        if (alu_fl_mask[3]) flag_q[`CAD_FL_NEG] <= alu_fl[3];
        if (alu_fl_mask[4]) flag_q[`CAD_FL_HALF] <= alu_fl[4];
      end
      if (take && op.cls == CAD_CLS_DSP && dsp_upd) begin
        if (op.acc_b) begin
          flag_q[`CAD_FL_OB] <= dsp_ov31;
          if (dsp_ov39 || (dsp_ov31 &&
              !core_control_q[`CAD_CC_CLAMP_WIDTH] &&
              core_control_q[`CAD_CC_ACC_B_CLAMP])) begin
            flag_q[`CAD_FL_SB] <= 1'b1;
          end
        end else begin
          flag_q[`CAD_FL_OA] <= dsp_ov31;
          if (dsp_ov39 || (dsp_ov31 &&
              !core_control_q[`CAD_CC_CLAMP_WIDTH] &&
              core_control_q[`CAD_CC_ACC_A_CLAMP])) begin
            flag_q[`CAD_FL_SA] <= 1'b1;
          end
        end
      end
    end
  end

  // alu and multiply results
  always_ff @(posedge core_clk) begin
    if (rst) begin
      res_valid <= 1'b0;
      res <= '0;
    end else if (clk_en) begin
      res_valid <= take && (op.cls == CAD_CLS_ALU || op.cls == CAD_CLS_MUL);
      if (take && op.cls == CAD_CLS_ALU) begin
        res <= '{data: alu_res, data_hi: 16'h0, dst_mem: op.dst_mem};
      end else if (take && op.cls == CAD_CLS_MUL) begin
        res <= '{data: mul_res[15:0], data_hi: mul_res[31:16],
          dst_mem: 1'b0};
      end
    end
  end

  // divider: restoring, sixteen steps on magnitudes
  assign dstep = div_step(div_rem_q, div_quo_q[15], div_dvs_q);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_st_q <= CAD_DIV_IDLE;
      div_cnt_q <= 5'h0;
      div_rem_q <= 16'h0;
      div_quo_q <= 16'h0;
      div_dvs_q <= 16'h0;
      div_neg_q_q <= 1'b0;
      div_neg_r_q <= 1'b0;
      div_valid <= 1'b0;
      quotient_reg <= 16'h0;
      remainder_reg <= 16'h0;
    end else if (clk_en) begin
      div_valid <= 1'b0;
      unique case (div_st_q)
        CAD_DIV_IDLE: begin
          if (take && op.cls == CAD_CLS_DIV) begin
            logic sn;
            logic [31:0] dd;
            dd = op.div_long ? {op.div_hi, op.wreg_a}
              : {{16{op.div_signed & op.wreg_a[15]}}, op.wreg_a};
            sn = op.div_signed & dd[31];
            dd = sn ? 32'(-dd) : dd;
            div_rem_q <= dd[31:16];
            div_quo_q <= dd[15:0];
            div_dvs_q <= mag16(op.opb, op.div_signed & op.opb[15]);
            div_neg_q_q <= sn ^ (op.div_signed & op.opb[15]);
            div_neg_r_q <= sn;
            div_cnt_q <= 5'h0;
            div_st_q <= CAD_DIV_BUSY;
          end
        end
        CAD_DIV_BUSY: begin
          div_rem_q <= dstep[15:0];
          div_quo_q <= {div_quo_q[14:0], dstep[16]};
          div_cnt_q <= 5'(div_cnt_q + 5'h1);
          if (div_cnt_q == 5'(`CAD_DIV_STEPS - 5'h1)) begin
            quotient_reg <= mag16({div_quo_q[14:0], dstep[16]},
              div_neg_q_q);
            remainder_reg <= mag16(dstep[15:0], div_neg_r_q);
            div_valid <= 1'b1;
            div_st_q <= CAD_DIV_IDLE;
          end
        end
      endcase
    end
  end
endmodule : cad_datapath

`default_nettype wire

// >>> src/cad_pkg.sv
// types shared by the arithmetic and dsp datapath
// assumes cad_consts.svh sits beside it
package cad_pkg;
  `include "cad_consts.svh"

  typedef enum logic [1:0] {
    CAD_CLS_ALU = 2'h0,
    CAD_CLS_MUL = 2'h1,
    CAD_CLS_DIV = 2'h2,
    CAD_CLS_DSP = 2'h3
  } cad_cls_t;

  typedef enum logic [2:0] {
    CAD_ALU_ADD = 3'h0,
    CAD_ALU_SUB = 3'h1,
    CAD_ALU_AND = 3'h2,
    CAD_ALU_OR = 3'h3,
    CAD_ALU_XOR = 3'h4,
    CAD_ALU_SHL = 3'h5,
    CAD_ALU_LSR = 3'h6,
    CAD_ALU_ASR = 3'h7
  } cad_alu_op_t;

  typedef enum logic [2:0] {
    CAD_MUL_SS = 3'h0,
    CAD_MUL_UU = 3'h1,
    CAD_MUL_S_LIT = 3'h2,
    CAD_MUL_U_LIT = 3'h3,
    CAD_MUL_US = 3'h4,
    CAD_MUL_BYTE = 3'h5
  } cad_mul_mode_t;

  typedef enum logic [3:0] {
    CAD_DSP_ACCUM_ZERO = 4'h0,
    CAD_DSP_DIFF_SQUARE = 4'h1,
    CAD_DSP_DIFF_SQUARE_ACCUM = 4'h2,
    CAD_DSP_MULT_ACCUMULATE = 4'h3,
    CAD_DSP_MULT_ACC_SQUARE = 4'h4,
    CAD_DSP_PREFETCH_ONLY_WB = 4'h5,
    CAD_DSP_MULTIPLY_LOAD = 4'h6,
    CAD_DSP_MULTIPLY_LOAD_SQ = 4'h7,
    CAD_DSP_NEGATED_MULT_LOAD = 4'h8,
    CAD_DSP_MULT_SUBTRACT = 4'h9,
    CAD_DSP_ACC_ADD = 4'hA,
    CAD_DSP_ACC_SUB = 4'hB,
    CAD_DSP_INVERT_SIGN_ACCUM = 4'hC
  } cad_dsp_op_t;

  typedef enum logic [1:0] {
    CAD_DIV_IDLE = 2'b01,
    CAD_DIV_BUSY = 2'b10
  } cad_div_state_t;

  typedef struct packed {
    cad_cls_t cls;
    cad_alu_op_t alu_op;
    logic byte_mode;
    cad_mul_mode_t mul_mode;
    logic div_signed;
    logic div_long;
    cad_dsp_op_t dsp_op;
    logic acc_b;
    logic wb_en;
    logic src_mem;
    logic dst_mem;
    logic [15:0] wreg_a;
    logic [15:0] mem_a;
    logic [15:0] opb;
    logic [4:0] lit5;
    logic [15:0] div_hi;
  } cad_op_t;

  typedef struct packed {
    logic [15:0] data;
    logic [15:0] data_hi;
    logic dst_mem;
  } cad_res_t;
endpackage : cad_pkg

// >>> tb/cad_datapath_properties.sv
// assertions on the datapath top ports
// assumes binding to cad_datapath with clk_en held high
`timescale 1ns/1ps
`default_nettype none
module cad_datapath_properties
  import cad_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // operations
  input wire logic op_valid,
  input wire cad_op_t op,
  input wire logic op_ready,
  input wire logic res_valid,
  input wire logic div_valid,
  input wire logic [15:0] quotient_reg,
  // priority
  input wire logic priority_msb_set,
  input wire logic [3:0] cpu_priority,
  input wire logic user_int_dis
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = op_valid && op_ready;
  sequence s_div_busy;
    !op_ready [*8] ##1 !op_ready [*8];
  endsequence
  a_div_length: assert property (take && op.cls == CAD_CLS_DIV
    |=> s_div_busy ##1 (op_ready && div_valid)) else $error("div length");
  a_res_answer: assert property (take && op.cls inside
    {CAD_CLS_ALU, CAD_CLS_MUL} |=> res_valid) else $error("no result");
  a_res_cause: assert property (res_valid |-> $past(take) &&
    $past(op.cls) inside {CAD_CLS_ALU, CAD_CLS_MUL}) else $error("stray");
  a_quot_source: assert property ($changed(quotient_reg) &&
    !$past(rst) |-> div_valid) else $error("quotient moved");
  a_wait_one: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("wait length");
  a_idle_nowait: assert property (!(read || write)
    |-> !waitrequest) else $error("idle wait");
  a_level_top: assert property (cpu_priority[3] == user_int_dis)
    else $error("priority top bit");
  a_msb_set: assert property (priority_msb_set
    |=> user_int_dis && cpu_priority[3]) else $error("msb not set");
endmodule : cad_datapath_properties
`default_nettype wire

// >>> tb/cad_decoder_model.sv
// decoder stand-in: presents operations to the datapath
// assumes callers enter issue right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cad_decoder_model
  import cad_pkg::*;
(
  // clock
  input wire logic core_clk,
  // operation handshake
  input wire logic op_ready,
  output logic op_valid,
  output cad_op_t op
);
  initial begin
    op_valid = 1'b0;
    op = '0;
  end
  // fetched operands held until taken
  task automatic issue(input cad_op_t o);
    op <= o;
    op_valid <= 1'b1;
    @(posedge core_clk);
    while (!op_ready) @(posedge core_clk);
  endtask : issue
  // released bus shows the inverse of its last value
  task automatic idle();
    op_valid <= 1'b0;
    op <= ~op;
  endtask : idle
endmodule : cad_decoder_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the arithmetic datapath
// assumes the decoder model and checker files compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module testbench;
  import cad_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
  logic priority_msb_set = 1'b0, op_ready, res_valid, div_valid, wb_valid;
  logic waitrequest, op_valid, user_int_dis;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, rd, r, e, p;
  logic [15:0] quotient_reg, remainder_reg, wb_data, b;
  logic [3:0] cpu_priority;
  logic [32:0] e33;
  cad_op_t op, o;
  cad_res_t res;
  logic [32:0] res_q[$];
  logic [31:0] div_q[$], wb_q[$];
  integer n_errors = 0, n_checks = 0, seed = 63249;
  always #5 core_clk = ~core_clk;
  cad_datapath dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .op_valid(op_valid),
    .op(op), .op_ready(op_ready), .res_valid(res_valid), .res(res),
    .div_valid(div_valid), .quotient_reg(quotient_reg),
    .remainder_reg(remainder_reg), .wb_valid(wb_valid), .wb_data(wb_data),
    .priority_msb_set(priority_msb_set), .cpu_priority(cpu_priority),
    .user_int_dis(user_int_dis));
  cad_decoder_model dec (.core_clk(core_clk), .op_ready(op_ready),
    .op_valid(op_valid), .op(op));
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge core_clk); while (waitrequest);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic alu(input cad_alu_op_t f, input logic [15:0] a, input logic [15:0] c);
    o = '0;
    o.cls = CAD_CLS_ALU;
    o.alu_op = f;
    o.wreg_a = a;
    o.opb = c;
    case (f)
      CAD_ALU_ADD: p = {16'h0, a + c};
      CAD_ALU_SUB: p = {16'h0, a - c};
      CAD_ALU_AND: p = {16'h0, a & c};
      CAD_ALU_OR: p = {16'h0, a | c};
      CAD_ALU_XOR: p = {16'h0, a ^ c};
      CAD_ALU_SHL: p = {16'h0, a << 1};
      CAD_ALU_LSR: p = {16'h0, a >> 1};
      default: p = {16'h0, $signed(a) >>> 1};
    endcase
    res_q.push_back({1'b0, p});
    dec.issue(o);
  endtask : alu
  task automatic mul(input logic s, input logic [15:0] a, input logic [15:0] c);
    o = '0;
    o.cls = CAD_CLS_MUL;
    o.mul_mode = s ? CAD_MUL_SS : CAD_MUL_UU;
    o.wreg_a = a;
    o.opb = c;
    if (s) p = $signed(a) * $signed(c);
    else p = a * c;
    res_q.push_back({1'b1, p});
    dec.issue(o);
  endtask : mul
  task automatic div(input logic s, input logic l, input logic [31:0] n,
    input logic [15:0] d, input logic [31:0] x);
    o = '0;
    o.cls = CAD_CLS_DIV;
    o.div_signed = s;
    o.div_long = l;
    o.wreg_a = n[15:0];
    o.div_hi = n[31:16];
    o.opb = d;
    div_q.push_back(x);
    dec.issue(o);
  endtask : div
  always @(posedge core_clk) begin
    if (res_valid) begin
      e33 = res_q.pop_front();
      `CHK(res.data, e33[15:0])
      if (e33[32]) `CHK(res.data_hi, e33[31:16])
    end
    if (div_valid) begin
      e = div_q.pop_front();
      `CHK({remainder_reg, quotient_reg}, e)
    end
    if (wb_valid) begin
      e = wb_q.pop_front();
      `CHK({16'h0, wb_data}, e)
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1'b0, `CAD_OFS_CORE_CONTROL, 32'h0);
    `CHK(rd, {16'h0, `CAD_CC_RESET})
    bus(1'b0, 5'h18, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, `CAD_OFS_CORE_CONTROL, 32'hFFFF);
    bus(1'b0, `CAD_OFS_CORE_CONTROL, 32'h0);
    `CHK(rd, 32'h10F7)
    priority_msb_set <= 1'b1;
    @(posedge core_clk);
    priority_msb_set <= 1'b0;
    bus(1'b0, `CAD_OFS_CORE_CONTROL, 32'h0);
    `CHK(rd, 32'h10FF)
    `CHK(user_int_dis, 1'b1)
    bus(1'b1, `CAD_OFS_CORE_CONTROL, 32'h0);
    bus(1'b0, `CAD_OFS_CORE_CONTROL, 32'h0);
    `CHK(rd, 32'h0)
    alu(CAD_ALU_SUB, 16'h0001, 16'h0002);
    dec.idle();
    bus(1'b0, `CAD_OFS_FLAG_REGISTER, 32'h0);
    `CHK(rd, 32'h0008)
    alu(CAD_ALU_SUB, 16'h0005, 16'h0005);
    dec.idle();
    bus(1'b0, `CAD_OFS_FLAG_REGISTER, 32'h0);
    `CHK(rd, 32'h0103)
    bus(1'b1, `CAD_OFS_FLAG_REGISTER, 32'h00A0);
    `CHK(cpu_priority, 4'h5)
    bus(1'b1, `CAD_OFS_CORE_CONTROL, 32'h0001);
    o = '0;
    o.cls = CAD_CLS_DSP;
    o.dsp_op = CAD_DSP_MULT_ACCUMULATE;
    o.wreg_a = 16'h4000;
    o.opb = 16'h4000;
    dec.issue(o);
    o.dsp_op = CAD_DSP_PREFETCH_ONLY_WB;
    o.acc_b = 1'b1;
    o.wb_en = 1'b1;
    wb_q.push_back(32'h1000);
    dec.issue(o);
    dec.idle();
    bus(1'b0, `CAD_OFS_ACCUMULATOR_A_LO, 32'h0);
    `CHK(rd, 32'h10000000)
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      alu(cad_alu_op_t'(i % 8), r[15:0], r[31:16]);
    end
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      mul(i[0], r[15:0], r[31:16]);
    end
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      b = r[31:16] | 16'h0001;
      div(1'b0, 1'b0, {16'h0, r[15:0]}, b, {r[15:0] % b, r[15:0] / b});
    end
    div(1'b1, 1'b1, 32'hFFFE7960, 16'h0007, 32'hFFFBC833);
    div(1'b0, 1'b1, 32'h00010000, 16'h0002, 32'h00008000);
    div(1'b1, 1'b0, 32'h0000FFF9, 16'h0002, 32'hFFFFFFFD);
    dec.idle();
    repeat (24) @(posedge core_clk);
    `CHK(res_q.size() + div_q.size() + wb_q.size(), 0)
    complete_run();
  end
  initial begin
    #50000;
    n_errors++;
    complete_run();
  end
endmodule : testbench
bind cad_datapath cad_datapath_properties u_props (.*);
`default_nettype wire
